// file: stat_bank_consts.svh
// constants for the statistics counter bank
`ifndef STAT_BANK_CONSTS_SVH
`define STAT_BANK_CONSTS_SVH

// ----------------------------------------------------------------
// counter array geometry
// ----------------------------------------------------------------
`define CNT_NUM 224
`define CNT_W 24
`define CNT_MAX24 24'hFFFFFF
`define CNT_MAX16 16'hFFFF
`define CNT_ZERO 24'h000000
`define IN_PORTS 24
`define LINKS 16
`define IN_BASE 8'h00
`define TX_BASE 8'h60
`define RX_BASE 8'hA0
`define RX_USER_TYPE 8'h10
`define EXEMPT_IDX 95
`define EXEMPT_ID 16'h0177

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_CMD 16'h040F
`define ADDR_HI 16'h0430
`define ADDR_LO 16'h0431
`define ADDR_SEL 16'h0432

// ----------------------------------------------------------------
// selector id layout
// ----------------------------------------------------------------
`define BLK_IN 2'h1
`define BLK_TX 2'h2
`define BLK_RX 2'h3

// ----------------------------------------------------------------
// command codes: mask and match on the low byte
// ----------------------------------------------------------------
`define CMD_RD_MASK 8'hB7
`define CMD_RD_VAL 8'h05
`define CMD_WR_MASK 8'hB7
`define CMD_WR_VAL 8'h01
`define CMD_EN_MASK 8'hBF
`define CMD_EN_VAL 8'h0A
`define CMD_DIS_MASK 8'h1F
`define CMD_DIS_VAL 8'h02
`define CMD_LATCH_EN_BIT 8
`define CMD_PIN_SRC_BIT 9
`define CMD_DIV_BIT 10
`define CMD_SW_LATCH_BIT 11

// ----------------------------------------------------------------
// latch pin divider
// ----------------------------------------------------------------
`define DIV_LAST 13'h1F3F

`endif

// file: stat_bank_pkg.sv
// types shared by the statistics counter bank
package stat_bank_pkg;

   // one register access on the management port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_type;

   // latch configuration held in the command register
   typedef struct packed {
      logic divide;
      logic pin_src;
      logic enable;
   } latch_cfg_type;

endpackage : stat_bank_pkg

// file: statistics_counter_bank.sv
// statistics counter bank: 224 event counters with read, preload and latch
// Operation
// - 224 separate counters, 24 bits wide when not latching.
// - reset clears every counter to zero.
// - each event adds one; all ones wraps to zero as overflow.
// - overflow raises an interrupt request, maskable per counter.
// - software may preload any counter with a start value.
// - 24 input ports keep four counters each, 96 in all.
// - 16 transmit links keep four counters each, 64 in all.
// - 16 receive links keep four counters each, counting once enabled.
// - receive user-cell counting includes stuff cells.
// - select counter, issue read, value copies into two holding registers.
// - holding registers keep the copied value until the next read or holding write.
// - fill holding, select, issue write; device loads that counter.
// - enable code unmasks, disable code masks selected counter's interrupt.
// - latching mode snapshots all counters at once, by pin or software.
// - pin pulses used directly or divided by 8000 as configured.
// - counters other than id 0x0177 are 16 bits while latching, 24 bits otherwise.
// - every latch event resets all counters other than id 0x0177 to zero, or to one if an event arrives that cycle; a same-cycle preload of a counter wins.
// - counter id 0x0177 is never cleared by a latch.
// - interrupt sources enable individually; only a disable or write command clears pending.
// - enabled overflow on a link's counters shows in its summary bit.
`timescale 1ns/1ps
`default_nettype none
`include "stat_bank_consts.svh"

module statistics_counter_bank (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // management register port
   input wire stat_bank_pkg::reg_req_type reg_req,
   output logic [15:0] reg_rdata,
   // counted events, one bit per counter
   input wire logic [`CNT_NUM-1:0] event_in,
   // receive link enables and stuff events
   input wire logic [`LINKS-1:0] rx_link_enable,
   input wire logic [`LINKS-1:0] rx_stuff_event,
   input wire logic rx_user_select,
   // latch trigger pin
   input wire logic latch_pin,
   // overflow summaries and latching mode status
   output logic [`LINKS-1:0] link_irq_status,
   output logic [`IN_PORTS-1:0] port_irq_status,
   output logic latch_active
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [`CNT_W-1:0] cnt_reg [`CNT_NUM];
   logic [`CNT_W-1:0] snap_reg [`CNT_NUM];
   logic [`CNT_NUM-1:0] ovf_reg;
   logic [`CNT_NUM-1:0] ie_reg;
   logic [`CNT_NUM-1:0] inc;
   logic [`CNT_NUM-1:0] wrap;
   logic [7:0] hold_hi_reg;
   logic [15:0] hold_lo_reg;
   logic [15:0] sel_reg;
   logic [7:0] cmd_low_reg;
   stat_bank_pkg::latch_cfg_type cfg_reg;
   logic [15:0] rdata_reg;
   logic [`LINKS-1:0] link_irq_reg;
   logic [`IN_PORTS-1:0] port_irq_reg;
   logic sync1_reg, sync2_reg, sync3_reg;
   logic [12:0] div_reg;

   // ---------------------------------------------------------------
   // selector decode
   // ---------------------------------------------------------------
   // maps a selector id to {valid, flat index}
   function automatic logic [8:0] id_to_idx(input logic [15:0] id);
      logic [7:0] typ;
      logic [8:0] res;
      typ = {6'h00, id[6:5]};
      res = 9'h000;
      if (id[15:10] == 6'h00 && id[7] == 1'b0) begin
         unique case (id[9:8])
            `BLK_IN: begin
               if (id[4:0] < 5'(`IN_PORTS))
                  res = {1'b1, 8'(typ * 8'h18) + {3'h0, id[4:0]}};
            end
            `BLK_TX: begin
               if (id[4] == 1'b0)
                  res = {1'b1, `TX_BASE + 8'(typ << 4) + {4'h0, id[3:0]}};
            end
            `BLK_RX: begin
               if (id[4] == 1'b0)
                  res = {1'b1, `RX_BASE + 8'(typ << 4) + {4'h0, id[3:0]}};
            end
            default: res = 9'h000;
         endcase
      end
      return res;
   endfunction : id_to_idx

   logic [8:0] sel_dec;
   logic sel_ok;
   logic [7:0] sel_idx;
   logic cmd_wr;
   logic [7:0] cmd_code;
   logic do_read, do_write, do_en, do_dis, sw_latch;
   logic pin_edge, pin_trig, latch_go;

   assign sel_dec = id_to_idx(sel_reg);
   assign sel_ok = sel_dec[8];
   assign sel_idx = sel_dec[7:0];
   assign cmd_wr = reg_req.wr && reg_req.addr == `ADDR_CMD;
   assign cmd_code = reg_req.wdata[7:0];
   assign do_read = cmd_wr && (cmd_code & `CMD_RD_MASK) == `CMD_RD_VAL;
   assign do_write = cmd_wr && (cmd_code & `CMD_WR_MASK) == `CMD_WR_VAL;
   assign do_en = cmd_wr && (cmd_code & `CMD_EN_MASK) == `CMD_EN_VAL;
   assign do_dis = cmd_wr && (cmd_code & `CMD_DIS_MASK) == `CMD_DIS_VAL;
   assign sw_latch = cmd_wr && reg_req.wdata[`CMD_SW_LATCH_BIT];

   // ---------------------------------------------------------------
   // latch trigger
   // ---------------------------------------------------------------
   // pin synchroniser and edge detect
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end else begin
         sync1_reg <= latch_pin;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end
   assign pin_edge = sync2_reg && !sync3_reg;

   always_ff @(posedge core_clk) begin
      if (rst || !cfg_reg.divide)
         div_reg <= 13'h0000;
      else if (pin_edge)
         div_reg <= (div_reg == `DIV_LAST) ? 13'h0000 : div_reg + 13'h0001;
   end
   assign pin_trig = pin_edge && (!cfg_reg.divide || div_reg == `DIV_LAST);

   // latch from pin or software while enabled
   assign latch_go = cfg_reg.enable &&
                     ((cfg_reg.pin_src && pin_trig) || sw_latch);

   // ---------------------------------------------------------------
   // management registers
   // ---------------------------------------------------------------
   // selector and command readback
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sel_reg <= 16'h0000;
         cmd_low_reg <= 8'h00;
         cfg_reg <= '0;
      end else begin
         if (reg_req.wr && reg_req.addr == `ADDR_SEL)
            sel_reg <= reg_req.wdata;
         if (cmd_wr) begin
            cmd_low_reg <= cmd_code;
            cfg_reg.enable <= reg_req.wdata[`CMD_LATCH_EN_BIT];
            cfg_reg.pin_src <= reg_req.wdata[`CMD_PIN_SRC_BIT];
            cfg_reg.divide <= reg_req.wdata[`CMD_DIV_BIT];
         end
      end
   end

   // holding registers take a read copy or a direct write; stable otherwise
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hold_hi_reg <= 8'h00;
         hold_lo_reg <= 16'h0000;
      end else if (do_read) begin
         if (!sel_ok)
            {hold_hi_reg, hold_lo_reg} <= `CNT_ZERO;
         else if (cfg_reg.enable)
            {hold_hi_reg, hold_lo_reg} <= snap_reg[sel_idx];
         else
            {hold_hi_reg, hold_lo_reg} <= cnt_reg[sel_idx];
      end else if (reg_req.wr && reg_req.addr == `ADDR_HI) begin
         hold_hi_reg <= reg_req.wdata[7:0];
      end else if (reg_req.wr && reg_req.addr == `ADDR_LO) begin
         hold_lo_reg <= reg_req.wdata;
      end
   end

   // read data, one cycle after the read strobe
   always_ff @(posedge core_clk) begin
      if (rst)
         rdata_reg <= 16'h0000;
      else if (reg_req.rd) begin
         unique case (reg_req.addr)
            `ADDR_CMD: rdata_reg <= {5'h00, cfg_reg.divide, cfg_reg.pin_src,
                                     cfg_reg.enable, cmd_low_reg};
            `ADDR_HI: rdata_reg <= {8'h00, hold_hi_reg};
            `ADDR_LO: rdata_reg <= hold_lo_reg;
            `ADDR_SEL: rdata_reg <= sel_reg;
            default: rdata_reg <= 16'h0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // counter array
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `CNT_NUM; gi++) begin : g_cnt
         logic hit;
         logic narrow;
         assign hit = sel_ok && sel_idx == 8'(gi);
         // exempt counter keeps full width, never cleared by a latch
         assign narrow = cfg_reg.enable && gi != `EXEMPT_IDX;
         if (gi >= `RX_BASE + `RX_USER_TYPE &&
             gi < `RX_BASE + `RX_USER_TYPE + `LINKS) begin : g_user
            // gated by link enable; stuff in user count
            assign inc[gi] = rx_link_enable[gi % `LINKS] &&
               (event_in[gi] || (rx_user_select && rx_stuff_event[gi % `LINKS]));
         end else if (gi >= `RX_BASE) begin : g_rx
            // receive counters run once the link is enabled
            assign inc[gi] = rx_link_enable[gi % `LINKS] && event_in[gi];
         end else begin : g_other
            // input port counters; transmit link counters
            assign inc[gi] = event_in[gi];
         end
         // all ones wraps; 16-bit limit while latching
         assign wrap[gi] = inc[gi] && (narrow ?
            cnt_reg[gi][15:0] == `CNT_MAX16 : cnt_reg[gi] == `CNT_MAX24);

         always_ff @(posedge core_clk) begin
            if (rst)
               cnt_reg[gi] <= `CNT_ZERO;
            else if (do_write && hit)
               cnt_reg[gi] <= {hold_hi_reg, hold_lo_reg};
            else if (latch_go && gi != `EXEMPT_IDX)
               cnt_reg[gi] <= {23'h000000, inc[gi]};
            else if (wrap[gi])
               cnt_reg[gi] <= `CNT_ZERO;
            else if (inc[gi])
               cnt_reg[gi] <= narrow ? {8'h00, cnt_reg[gi][15:0] + 16'h0001}
                                     : cnt_reg[gi] + 24'h000001;
         end

         // all snapshots taken on the same edge
         always_ff @(posedge core_clk) begin
            if (rst)
               snap_reg[gi] <= `CNT_ZERO;
            else if (latch_go)
               snap_reg[gi] <= cnt_reg[gi];
         end

         always_ff @(posedge core_clk) begin
            if (rst)
               ie_reg[gi] <= 1'b0;
            else if (do_en && hit)
               ie_reg[gi] <= 1'b1;
            else if (do_dis && hit)
               ie_reg[gi] <= 1'b0;
         end

         // sticky overflow, cleared by mask or preload, set wins
         always_ff @(posedge core_clk) begin
            if (rst)
               ovf_reg[gi] <= 1'b0;
            else if (wrap[gi])
               ovf_reg[gi] <= 1'b1;
            else if ((do_dis || do_write) && hit)
               ovf_reg[gi] <= 1'b0;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // overflow summaries
   // ---------------------------------------------------------------
   logic [`CNT_NUM-1:0] pend;
   assign pend = ovf_reg & ie_reg;

   // per link and per input port summary of enabled overflows
   always_ff @(posedge core_clk) begin
      if (rst) begin
         link_irq_reg <= '0;
         port_irq_reg <= '0;
      end else begin
         for (int l = 0; l < `LINKS; l++)
            link_irq_reg[l] <= pend[96 + l] | pend[112 + l] | pend[128 + l] |
                               pend[144 + l] | pend[160 + l] | pend[176 + l] |
                               pend[192 + l] | pend[208 + l];
         for (int p = 0; p < `IN_PORTS; p++)
            port_irq_reg[p] <= pend[p] | pend[24 + p] | pend[48 + p] |
                               pend[72 + p];
      end
   end

   assign reg_rdata = rdata_reg;
   assign link_irq_status = link_irq_reg;
   assign port_irq_status = port_irq_reg;
   assign latch_active = cfg_reg.enable;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_read_cmd;
      do_read && sel_ok && !cfg_reg.enable;
   endsequence

   sequence s_quiet_hold;
      !do_read && !(reg_req.wr &&
         (reg_req.addr == `ADDR_HI || reg_req.addr == `ADDR_LO));
   endsequence

   property p_reset_clear;
      rst |=> cnt_reg[0] == `CNT_ZERO && cnt_reg[223] == `CNT_ZERO;
   endproperty
   a_reset_clear: assert property (disable iff (1'b0) p_reset_clear)
      else $error("counter not cleared by reset");

   property p_read_copy;
      logic [23:0] v;
      (s_read_cmd, v = cnt_reg[sel_idx]) |=> {hold_hi_reg, hold_lo_reg} == v;
   endproperty
   a_read_copy: assert property (p_read_copy)
      else $error("holding registers missed the read copy");

   property p_hold_stable;
      s_quiet_hold |=> $stable({hold_hi_reg, hold_lo_reg});
   endproperty
   a_hold_stable: assert property (p_hold_stable)
      else $error("holding registers changed without a read");

   property p_preload;
      logic [7:0] i;
      (do_write && sel_ok, i = sel_idx) |=>
         cnt_reg[i] == $past({hold_hi_reg, hold_lo_reg});
   endproperty
   a_preload: assert property (p_preload)
      else $error("preload value not taken");

   property p_irq_enable;
      logic [7:0] i;
      (do_en && sel_ok, i = sel_idx) |=>
         ie_reg[i] ##1 (ie_reg[i] || $past(do_dis));
   endproperty
   a_irq_enable: assert property (p_irq_enable)
      else $error("interrupt enable command not applied");

   property p_wrap;
      !cfg_reg.enable && inc[3] && cnt_reg[3] == `CNT_MAX24 &&
         !latch_go && !(do_write && sel_idx == 8'h03)
         |=> cnt_reg[3] == `CNT_ZERO && ovf_reg[3];
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("counter did not wrap with overflow");

   property p_latch_clear;
      latch_go && !inc[8] && !(do_write && sel_idx == 8'h08)
         |=> cnt_reg[8] == `CNT_ZERO && snap_reg[8] == $past(cnt_reg[8]);
   endproperty
   a_latch_clear: assert property (p_latch_clear)
      else $error("latch did not snapshot and clear");

   property p_exempt;
      latch_go && !inc[`EXEMPT_IDX] && !do_write
         |=> $stable(cnt_reg[`EXEMPT_IDX]);
   endproperty
   a_exempt: assert property (p_exempt)
      else $error("exempt counter cleared by latch");

   property p_div;
      cfg_reg.divide && cfg_reg.enable && cfg_reg.pin_src && !cmd_wr &&
         pin_edge && div_reg != `DIV_LAST |-> !latch_go;
   endproperty
   a_div: assert property (p_div)
      else $error("latch issued before 8000 pin edges");

   property p_summary;
      pend[133] |=> link_irq_status[5];
   endproperty
   a_summary: assert property (p_summary)
      else $error("link summary missed an enabled overflow");

endmodule : statistics_counter_bank
`default_nettype wire

// file: statistics_counter_bank_tb_top.sv
// self-checking testbench for the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
`include "stat_bank_consts.svh"

module statistics_counter_bank_tb_top;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic core_clk;
   logic rst;
   stat_bank_pkg::reg_req_type reg_req;
   logic [15:0] reg_rdata;
   logic [`CNT_NUM-1:0] event_in;
   logic [`LINKS-1:0] rx_link_enable;
   logic [`LINKS-1:0] rx_stuff_event;
   logic rx_user_select;
   logic latch_pin;
   logic [`LINKS-1:0] link_irq_status;
   logic [`IN_PORTS-1:0] port_irq_status;
   logic latch_active;
   int err_count;
   int checked;
   logic [23:0] val;
   logic [15:0] r16;

   statistics_counter_bank i_dut (
      .core_clk(core_clk),
      .rst(rst),
      .reg_req(reg_req),
      .reg_rdata(reg_rdata),
      .event_in(event_in),
      .rx_link_enable(rx_link_enable),
      .rx_stuff_event(rx_stuff_event),
      .rx_user_select(rx_user_select),
      .latch_pin(latch_pin),
      .link_irq_status(link_irq_status),
      .port_irq_status(port_irq_status),
      .latch_active(latch_active)
   );

   // 250 MHz system clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // compare, access and stimulus tasks
   // ------------------------------------------------------------
   task automatic chk_cnt(input string name, input logic [23:0] exp,
      input logic [23:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_cnt

   task automatic chk_bit(input string name, input logic exp,
      input logic got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   // one write strobe, launched and released on falling edges
   task automatic wr_reg(input logic [15:0] addr, input logic [15:0] data);
      @(negedge core_clk);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(negedge core_clk);
      reg_req = '0;
   endtask : wr_reg

   // read data is registered on the taking edge; sampled a cycle and a half later
   task automatic rd_reg(input logic [15:0] addr, output logic [15:0] data);
      @(negedge core_clk);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
      @(negedge core_clk);
      reg_req = '0;
      @(negedge core_clk);
      data = reg_rdata;
   endtask : rd_reg

   task automatic rd_hold(output logic [23:0] v);
      logic [15:0] hi;
      logic [15:0] lo;
      rd_reg(`ADDR_HI, hi);
      rd_reg(`ADDR_LO, lo);
      v = {hi[7:0], lo};
   endtask : rd_hold

   task automatic get_cnt(input logic [15:0] id, input logic [15:0] code,
      output logic [23:0] v);
      wr_reg(`ADDR_SEL, id);
      wr_reg(`ADDR_CMD, code);
      rd_hold(v);
   endtask : get_cnt

   // preload with don't-care bits of the write code set
   task automatic put_cnt(input logic [15:0] id, input logic [23:0] v);
      wr_reg(`ADDR_HI, {8'h00, v[23:16]});
      wr_reg(`ADDR_LO, v[15:0]);
      wr_reg(`ADDR_SEL, id);
      wr_reg(`ADDR_CMD, 16'h0049);
   endtask : put_cnt

   // hold one event bit high for n cycles, n events
   task automatic ev(input int idx, input int n);
      @(negedge core_clk);
      event_in[idx] = 1'b1;
      repeat (n) @(negedge core_clk);
      event_in[idx] = 1'b0;
   endtask : ev

   task automatic pin(input int n);
      repeat (n) begin
         @(negedge core_clk);
         latch_pin = 1'b1;
         repeat (2) @(negedge core_clk);
         latch_pin = 1'b0;
         @(negedge core_clk);
      end
   endtask : pin

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test

   // watchdog well beyond the expected run length
   initial begin
      #400000;
      err_count++;
      end_of_test();
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      reg_req = '0;
      event_in = '0;
      rx_link_enable = '0;
      rx_stuff_event = '0;
      rx_user_select = 1'b0;
      latch_pin = 1'b0;
      err_count = 0;
      checked = 0;
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      get_cnt(16'h0103, 16'h0005, val);
      chk_cnt("reset count", 24'h000000, val);
      rd_reg(16'h0500, r16);
      chk_cnt("unmapped read", 24'h000000, {8'h00, r16});
      chk_bit("latch idle", 1'b0, latch_active);
      $display("test reset done");
      put_cnt(16'h0103, 24'hFFFFFE);
      get_cnt(16'h0103, 16'h004D, val);
      chk_cnt("preload read", 24'hFFFFFE, val);
      wr_reg(`ADDR_CMD, 16'h004A);
      ev(3, 2);
      get_cnt(16'h0103, 16'h0005, val);
      chk_cnt("wrap to zero", 24'h000000, val);
      chk_bit("port irq set", 1'b1, port_irq_status[3]);
      ev(3, 5);
      rd_hold(val);
      chk_cnt("holding kept", 24'h000000, val);
      get_cnt(16'h0103, 16'h0005, val);
      chk_cnt("count after wrap", 24'h000005, val);
      chk_bit("irq kept on read", 1'b1, port_irq_status[3]);
      wr_reg(`ADDR_CMD, 16'h00E2);
      repeat (3) @(negedge core_clk);
      chk_bit("port irq masked", 1'b0, port_irq_status[3]);
      $display("test wrap and irq done");
      put_cnt(16'h0245, 24'hFFFFFF);
      ev(133, 1);
      repeat (3) @(negedge core_clk);
      chk_bit("masked link irq", 1'b0, link_irq_status[5]);
      put_cnt(16'h0245, 24'hFFFFFF);
      wr_reg(`ADDR_CMD, 16'h000A);
      ev(133, 1);
      repeat (3) @(negedge core_clk);
      chk_bit("link irq set", 1'b1, link_irq_status[5]);
      $display("test link irq done");
      // receive counters gated by enable, stuff counted
      rx_user_select = 1'b1;
      ev(178, 3);
      get_cnt(16'h0322, 16'h0005, val);
      chk_cnt("rx disabled", 24'h000000, val);
      rx_link_enable[2] = 1'b1;
      ev(178, 3);
      rx_stuff_event[2] = 1'b1;
      repeat (2) @(negedge core_clk);
      rx_stuff_event[2] = 1'b0;
      get_cnt(16'h0322, 16'h0005, val);
      chk_cnt("rx user with stuff", 24'h000005, val);
      // stuff left out when user counting is off
      rx_user_select = 1'b0;
      rx_stuff_event[2] = 1'b1;
      repeat (2) @(negedge core_clk);
      rx_stuff_event[2] = 1'b0;
      get_cnt(16'h0322, 16'h0005, val);
      chk_cnt("rx stuff unselected", 24'h000005, val);
      $display("test receive done");
      // software latch, clear and exempt counter
      put_cnt(16'h0107, 24'h00FFFF);
      wr_reg(`ADDR_CMD, 16'h0100);
      chk_bit("latch on", 1'b1, latch_active);
      ev(7, 1);
      ev(8, 5);
      ev(`EXEMPT_IDX, 3);
      wr_reg(`ADDR_CMD, 16'h0900);
      ev(8, 2);
      ev(`EXEMPT_IDX, 1);
      get_cnt(16'h0107, 16'h0105, val);
      chk_cnt("16 bit wrap", 24'h000000, val);
      get_cnt(16'h0108, 16'h0105, val);
      chk_cnt("snapshot one", 24'h000005, val);
      get_cnt(`EXEMPT_ID, 16'h0105, val);
      chk_cnt("exempt one", 24'h000003, val);
      wr_reg(`ADDR_CMD, 16'h0900);
      get_cnt(16'h0108, 16'h0105, val);
      chk_cnt("snapshot two", 24'h000002, val);
      get_cnt(`EXEMPT_ID, 16'h0105, val);
      chk_cnt("exempt two", 24'h000004, val);
      $display("test software latch done");
      // pin latch divided by 8000, then direct
      wr_reg(`ADDR_CMD, 16'h0700);
      ev(8, 4);
      pin(7999);
      repeat (6) @(negedge core_clk);
      get_cnt(16'h0108, 16'h0705, val);
      chk_cnt("no latch before 8000", 24'h000002, val);
      pin(1);
      repeat (6) @(negedge core_clk);
      get_cnt(16'h0108, 16'h0705, val);
      chk_cnt("latch at 8000", 24'h000004, val);
      wr_reg(`ADDR_CMD, 16'h0300);
      ev(8, 6);
      pin(1);
      repeat (6) @(negedge core_clk);
      get_cnt(16'h0108, 16'h0305, val);
      chk_cnt("direct pin latch", 24'h000006, val);
      wr_reg(`ADDR_CMD, 16'h0000);
      repeat (2) @(negedge core_clk);
      chk_bit("latch off", 1'b0, latch_active);
      $display("test pin latch done");
      end_of_test();
   end

endmodule : statistics_counter_bank_tb_top
`default_nettype wire
